// ### shared/gpa_pkg.sv
package gpa_pkg;
	// Clock and link timer periods
	localparam int CLOCK_KHZ = 50000;
	localparam int TIMER_SGMII_US = 1600;
	localparam int TIMER_SERDES_US = 10000;
	localparam int TIMER_SGMII_CYC = TIMER_SGMII_US * CLOCK_KHZ / 1000;
	localparam int TIMER_SERDES_CYC = TIMER_SERDES_US * CLOCK_KHZ / 1000;
	localparam int TIMER_W = 20;
	localparam int CNT_W = 8;
	localparam int PAGE_W = 16;
	localparam int CODE_W = 10;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SD_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ANEG_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_NP_CFG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ANEG_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_NP_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LINK_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_LOSS_CNT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STICKY = 8'h20;
	// Field positions
	localparam int B_ON = 0;
	localparam int B_SGMII = 1;
	localparam int B_ONEWAY = 2;
	localparam int B_LOOP = 3;
	localparam int B_SD_REACT = 0;
	localparam int B_CARRIER_SENSE_POLARITY = 1;
	localparam int B_SD_SRC = 2;
	localparam int B_AN_ON = 0;
	localparam int B_AN_RESTART = 1;
	localparam int B_NP_LOADED = 0;
	localparam int B_PAGE_RX = 0;
	localparam int B_PR = 1;
	localparam int B_DONE = 2;
	localparam int B_LINK = 0;
	localparam int B_SYNC = 1;
	localparam int B_SD = 2;
	localparam int B_LOSS = 0;
	localparam int PAGE_LSB = 16;
	localparam int PAGE_BIT15 = 15;
	// Reset values
	localparam logic [PAGE_W-1:0] RST_PAGE = 16'h0000;
	localparam logic [CNT_W-1:0] RST_CNT = 8'h00;
	typedef enum logic [2:0] {
		AN_RESTART,
		AN_ABILITY,
		AN_PAGE_WAIT,
		AN_NEXT_PAGE,
		AN_IDLE_DETECT,
		AN_LINK_GOOD,
		AN_OFF_GOOD
	} gpa_an_state_t;
endpackage : gpa_pkg

// ### rtl/gpa_pcs_link_ctrl.sv
module gpa_pcs_link_ctrl
	import gpa_pkg::*;
#(
	parameter int SGMII_CYC = TIMER_SGMII_CYC,
	parameter int SERDES_CYC = TIMER_SERDES_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic pma_signal_detect,
	input wire logic gpio_signal_detect,
	input wire logic rx_sync_in,
	input wire logic rx_page_valid,
	input wire logic [PAGE_W-1:0] rx_page_word,
	output logic [PAGE_W-1:0] tx_page_word,
	output logic tx_page_active,
	output logic tx_enable,
	output logic rx_restart,
	output logic rx_frame_enable,
	output logic phy_side_serial_mode_select,
	input wire logic [CODE_W-1:0] tx_code_in,
	input wire logic [CODE_W-1:0] serdes_rx_code,
	output logic [CODE_W-1:0] rx_code_out
);
	logic bus_ack;
	logic wr_en;
	logic coding_sublayer_on;
	logic one_way_tx_enable;
	logic tx_to_rx_loopback_enable;
	logic loss_of_light_react_enable;
	logic carrier_sense_polarity;
	logic carrier_sense_source;
	logic autoneg_on;
	logic [PAGE_W-1:0] local_base_page_word;
	logic [PAGE_W-1:0] local_next_page_word;
	logic [PAGE_W-1:0] partner_base_page_word;
	logic [PAGE_W-1:0] partner_next_page_word;
	logic page_rx;
	logic priority_resolve_ready;
	logic autoneg_done_flag;
	logic link_status;
	logic sync_status;
	logic link_loss_sticky;
	logic [CNT_W-1:0] link_loss_counter;
	logic autoneg_restart_pulse;
	logic next_page_loaded_pulse;
	logic page_clr;
	logic loss_clr;
	logic sd_raw;
	logic sd_lost;
	logic sync_eff;
	logic an_run;
	logic page_set;
	logic good;
	logic loss_armed;
	logic loss_event;
	logic [TIMER_W-1:0] period_m1;
	logic [TIMER_W-1:0] an_timer;
	logic [TIMER_W-1:0] loss_timer;
	gpa_an_state_t state;
	gpa_an_state_t next_state;

	// Bus handshake: answer in the second cycle of each request
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
	assign wr_en = avs_write & bus_ack;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read | avs_write) & ~bus_ack;
		end
	end

	// Write strobes for one-shot and clear bits
	assign autoneg_restart_pulse = wr_en & (avs_address == OFS_ANEG_CFG) & avs_writedata[B_AN_RESTART];
	assign next_page_loaded_pulse = wr_en & (avs_address == OFS_NP_CFG) & avs_writedata[B_NP_LOADED];
	assign page_clr = wr_en & (avs_address == OFS_ANEG_STAT) & avs_writedata[B_PAGE_RX];
	assign loss_clr = wr_en & (avs_address == OFS_STICKY) & avs_writedata[B_LOSS];

	// Configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			coding_sublayer_on <= 1'b0;
			phy_side_serial_mode_select <= 1'b0;
			one_way_tx_enable <= 1'b0;
			tx_to_rx_loopback_enable <= 1'b0;
			loss_of_light_react_enable <= 1'b0;
			carrier_sense_polarity <= 1'b1;
			carrier_sense_source <= 1'b0;
			autoneg_on <= 1'b0;
			local_base_page_word <= RST_PAGE;
			local_next_page_word <= RST_PAGE;
		end else if (wr_en) begin
			unique case (avs_address)
				OFS_CFG: begin
					coding_sublayer_on <= avs_writedata[B_ON];
					phy_side_serial_mode_select <= avs_writedata[B_SGMII];
					one_way_tx_enable <= avs_writedata[B_ONEWAY];
					tx_to_rx_loopback_enable <= avs_writedata[B_LOOP];
				end
				OFS_SD_CFG: begin
					loss_of_light_react_enable <= avs_writedata[B_SD_REACT];
					carrier_sense_polarity <= avs_writedata[B_CARRIER_SENSE_POLARITY];
					carrier_sense_source <= avs_writedata[B_SD_SRC];
				end
				OFS_ANEG_CFG: begin
					autoneg_on <= avs_writedata[B_AN_ON];
					local_base_page_word <= avs_writedata[PAGE_LSB +: PAGE_W];
				end
				OFS_NP_CFG: begin
					local_next_page_word <= avs_writedata[PAGE_LSB +: PAGE_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data, captured in the waiting cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read & ~bus_ack) begin
			avs_readdata <= '0;
			unique case (avs_address)
				OFS_CFG: begin
					avs_readdata[B_ON] <= coding_sublayer_on;
					avs_readdata[B_SGMII] <= phy_side_serial_mode_select;
					avs_readdata[B_ONEWAY] <= one_way_tx_enable;
					avs_readdata[B_LOOP] <= tx_to_rx_loopback_enable;
				end
				OFS_SD_CFG: begin
					avs_readdata[B_SD_REACT] <= loss_of_light_react_enable;
					avs_readdata[B_CARRIER_SENSE_POLARITY] <= carrier_sense_polarity;
					avs_readdata[B_SD_SRC] <= carrier_sense_source;
				end
				OFS_ANEG_CFG: begin
					avs_readdata[B_AN_ON] <= autoneg_on;
					avs_readdata[PAGE_LSB +: PAGE_W] <= local_base_page_word;
				end
				OFS_NP_CFG: begin
					avs_readdata[PAGE_LSB +: PAGE_W] <= local_next_page_word;
				end
				OFS_ANEG_STAT: begin
					avs_readdata[B_PAGE_RX] <= page_rx;
					avs_readdata[B_PR] <= priority_resolve_ready;
					avs_readdata[B_DONE] <= autoneg_done_flag;
					avs_readdata[PAGE_LSB +: PAGE_W] <= partner_base_page_word;
				end
				OFS_NP_STAT: begin
					avs_readdata[PAGE_W-1:0] <= partner_next_page_word;
				end
				OFS_LINK_STAT: begin
					avs_readdata[B_LINK] <= link_status;
					avs_readdata[B_SYNC] <= sync_status;
					avs_readdata[B_SD] <= sd_raw;
				end
				OFS_LOSS_CNT: begin
					avs_readdata[CNT_W-1:0] <= link_loss_counter;
				end
				OFS_STICKY: begin
					avs_readdata[B_LOSS] <= link_loss_sticky;
				end
				default: begin
				end
			endcase
		end
	end

	assign sd_raw = carrier_sense_source ? gpio_signal_detect : pma_signal_detect;
	assign sd_lost = sd_raw != carrier_sense_polarity;
	assign rx_restart = coding_sublayer_on & loss_of_light_react_enable & sd_lost;
	assign rx_frame_enable = coding_sublayer_on & ~rx_restart;
	assign sync_eff = rx_frame_enable & rx_sync_in;
	assign an_run = coding_sublayer_on & autoneg_on & sync_eff & ~autoneg_restart_pulse;
	assign good = (state == AN_LINK_GOOD) | (state == AN_OFF_GOOD);
	assign period_m1 = phy_side_serial_mode_select ? TIMER_W'(SGMII_CYC - 1) : TIMER_W'(SERDES_CYC - 1);

	// Negotiation next state
	always_comb begin
		next_state = state;
		if (!coding_sublayer_on || !sync_eff) begin
			next_state = AN_RESTART;
		end else if (!autoneg_on) begin
			next_state = AN_OFF_GOOD;
		end else if (autoneg_restart_pulse) begin
			next_state = AN_RESTART;
		end else begin
			unique case (state)
				AN_RESTART, AN_OFF_GOOD: begin
					next_state = AN_ABILITY;
				end
				AN_ABILITY: begin
					if (rx_page_valid) begin
						next_state = local_base_page_word[PAGE_BIT15] ? AN_PAGE_WAIT : AN_IDLE_DETECT;
					end
				end
				AN_PAGE_WAIT: begin
					if (next_page_loaded_pulse) begin
						next_state = AN_NEXT_PAGE;
					end
				end
				AN_NEXT_PAGE: begin
					if (rx_page_valid) begin
						next_state = local_next_page_word[PAGE_BIT15] ? AN_PAGE_WAIT : AN_IDLE_DETECT;
					end
				end
				AN_IDLE_DETECT: begin
					if (an_timer == period_m1) begin
						next_state = AN_LINK_GOOD;
					end
				end
				AN_LINK_GOOD: begin
					next_state = AN_LINK_GOOD;
				end
			endcase
		end
	end

	// Negotiation state and idle timer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= AN_RESTART;
			an_timer <= '0;
		end else begin
			state <= next_state;
			an_timer <= (state == AN_IDLE_DETECT && next_state == AN_IDLE_DETECT) ? an_timer + 1'b1 : '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			priority_resolve_ready <= 1'b0;
			autoneg_done_flag <= 1'b0;
		end else begin
			priority_resolve_ready <= (next_state == AN_IDLE_DETECT) | (next_state == AN_LINK_GOOD);
			autoneg_done_flag <= next_state == AN_LINK_GOOD;
		end
	end

	// page capture, set wins over clear
	assign page_set = an_run & rx_page_valid & ((state == AN_ABILITY) | (state == AN_NEXT_PAGE));
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			page_rx <= 1'b0;
			partner_base_page_word <= RST_PAGE;
			partner_next_page_word <= RST_PAGE;
		end else begin
			page_rx <= page_set | (page_rx & ~page_clr);
			if (page_set && state == AN_ABILITY) begin
				partner_base_page_word <= rx_page_word;
			end
			if (page_set && state == AN_NEXT_PAGE) begin
				partner_next_page_word <= rx_page_word;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_page_word <= RST_PAGE;
			tx_page_active <= 1'b0;
		end else begin
			tx_page_word <= (state == AN_NEXT_PAGE) ? local_next_page_word : local_base_page_word;
			tx_page_active <= coding_sublayer_on & autoneg_on & ~good & (state != AN_IDLE_DETECT);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_status <= 1'b0;
			sync_status <= 1'b0;
			tx_enable <= 1'b0;
		end else begin
			link_status <= phy_side_serial_mode_select ? partner_base_page_word[PAGE_BIT15] : sync_eff;
			sync_status <= sync_eff;
			tx_enable <= coding_sublayer_on & (one_way_tx_enable | good);
		end
	end

	// link loss surveillance, armed by a good state
	assign loss_event = loss_armed & ~good & (loss_timer == period_m1);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			loss_armed <= 1'b0;
			loss_timer <= '0;
			link_loss_sticky <= 1'b0;
			link_loss_counter <= RST_CNT;
		end else begin
			loss_armed <= good | (loss_armed & ~loss_event);
			loss_timer <= (good || loss_event) ? '0 : loss_timer + 1'b1;
			link_loss_sticky <= loss_event | (link_loss_sticky & ~loss_clr);
			if (loss_event) begin
				link_loss_counter <= link_loss_counter + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_code_out <= '0;
		end else begin
			rx_code_out <= tx_to_rx_loopback_enable ? tx_code_in : serdes_rx_code;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_page_wait_load;
		state == AN_PAGE_WAIT && next_page_loaded_pulse && an_run;
	endsequence
	sequence s_enter_idle;
		state != AN_IDLE_DETECT ##1 state == AN_IDLE_DETECT;
	endsequence
	property p_off;
		!coding_sublayer_on |=> state == AN_RESTART && !tx_enable;
	endproperty
	a_off: assert property (p_off) else $error("state not reset when sublayer off");
	property p_oneway;
		coding_sublayer_on && one_way_tx_enable |=> tx_enable;
	endproperty
	a_oneway: assert property (p_oneway) else $error("one-way transmit not enabled");
	property p_restart;
		coding_sublayer_on && autoneg_on && autoneg_restart_pulse |=> state == AN_RESTART;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse ignored");
	property p_adv;
		state == AN_ABILITY |=> tx_page_word == $past(local_base_page_word);
	endproperty
	a_adv: assert property (p_adv) else $error("wrong base page sent");
	property p_page;
		page_set && state == AN_ABILITY |=> page_rx && partner_base_page_word == $past(rx_page_word);
	endproperty
	a_page: assert property (p_page) else $error("base page not captured");
	property p_np;
		s_page_wait_load |=> state == AN_NEXT_PAGE ##1 tx_page_word == $past(local_next_page_word);
	endproperty
	a_np: assert property (p_np) else $error("next page not sent after load");
	property p_pr;
		s_enter_idle |-> priority_resolve_ready;
	endproperty
	a_pr: assert property (p_pr) else $error("ready bit missing in idle detect");
	property p_good;
		state == AN_LINK_GOOD && $past(state) == AN_IDLE_DETECT |-> $past(an_timer) == period_m1;
	endproperty
	a_good: assert property (p_good) else $error("link good reached early");
	property p_done;
		state == AN_LINK_GOOD |-> autoneg_done_flag;
	endproperty
	a_done: assert property (p_done) else $error("done flag missing");
	property p_link;
		phy_side_serial_mode_select |=> link_status == $past(partner_base_page_word[PAGE_BIT15]);
	endproperty
	a_link: assert property (p_link) else $error("SGMII link state wrong");
	property p_loss;
		loss_event |=> link_loss_sticky && link_loss_counter == $past(link_loss_counter) + 1'b1;
	endproperty
	a_loss: assert property (p_loss) else $error("link loss not recorded");
	property p_sd;
		coding_sublayer_on && loss_of_light_react_enable && sd_lost |-> !rx_frame_enable ##1 !sync_status;
	endproperty
	a_sd: assert property (p_sd) else $error("signal loss not acted on");
endmodule : gpa_pcs_link_ctrl

// ### bench/gpa_link_partner.sv
module gpa_link_partner
	import gpa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_up,
	input wire logic send_next,
	input wire logic [3:0] gap,
	input wire logic [PAGE_W-1:0] base_word,
	input wire logic [PAGE_W-1:0] np_word,
	input wire logic tx_page_active,
	input wire logic [PAGE_W-1:0] tx_page_word,
	output logic rx_sync_in,
	output logic rx_page_valid,
	output logic [PAGE_W-1:0] rx_page_word,
	output logic [CODE_W-1:0] serdes_rx_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic [PAGE_W-1:0] seen_word;
	// Fixed idle code on the receive lane
	assign serdes_rx_code = 10'h17C;
	// Decoder lock follows the far side's link one cycle late
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_in <= 1'b0;
		end else begin
			rx_sync_in <= link_up;
		end
	end
	// Answer gap+1 cycles after our page settles, then keep repeating like a real partner
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			seen_word <= 16'h0000;
			rx_page_valid <= 1'b0;
			rx_page_word <= 16'h0000;
		end else begin
			seen_word <= tx_page_word;
			rx_page_valid <= 1'b0;
			rx_page_word <= ~rx_page_word; // No stale word between pages
			if (!tx_page_active || !link_up || tx_page_word != seen_word) begin
				cnt <= 4'h0;
			end else if (cnt == gap) begin
				cnt <= 4'h0;
				rx_page_valid <= 1'b1;
				rx_page_word <= send_next ? np_word : base_word;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule : gpa_link_partner

// ### bench/gpa_pcs_link_ctrl_test.sv
module gpa_pcs_link_ctrl_test
	import gpa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short link timers: SGMII 20 cycles, 1000BASE-X 50 cycles
	localparam int SG_CYC = 20;
	localparam int SX_CYC = 50;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic pma_signal_detect, gpio_signal_detect, rx_sync_in, rx_page_valid;
	logic [PAGE_W-1:0] rx_page_word, tx_page_word, base_word, np_word;
	logic tx_page_active, tx_enable, rx_restart, rx_frame_enable, phy_side_serial_mode_select;
	logic [CODE_W-1:0] tx_code_in, serdes_rx_code, rx_code_out;
	logic link_up, send_next;
	logic [3:0] gap;
	int err_total, samples_checked, cycles;

	gpa_pcs_link_ctrl #(.SGMII_CYC(SG_CYC), .SERDES_CYC(SX_CYC)) u_gpa_pcs_link_ctrl (
		.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pma_signal_detect(pma_signal_detect),
		.gpio_signal_detect(gpio_signal_detect), .rx_sync_in(rx_sync_in),
		.rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word),
		.tx_page_word(tx_page_word), .tx_page_active(tx_page_active), .tx_enable(tx_enable),
		.rx_restart(rx_restart), .rx_frame_enable(rx_frame_enable),
		.phy_side_serial_mode_select(phy_side_serial_mode_select), .tx_code_in(tx_code_in),
		.serdes_rx_code(serdes_rx_code), .rx_code_out(rx_code_out));

	gpa_link_partner u_gpa_link_partner (
		.clock(clock), .rst_n(rst_n), .link_up(link_up), .send_next(send_next), .gap(gap),
		.base_word(base_word), .np_word(np_word), .tx_page_active(tx_page_active),
		.tx_page_word(tx_page_word), .rx_sync_in(rx_sync_in), .rx_page_valid(rx_page_valid),
		.rx_page_word(rx_page_word), .serdes_rx_code(serdes_rx_code));

	// Verdict and end of run
	task tally_and_finish;
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		if (n >= 50) begin
			err_total++;
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a,
			input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(name, rd & mask, exp);
	endtask : rd_chk

	task automatic poll_page;
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_ANEG_STAT, 32'h00000000);
			n++;
		end while (rd[B_PAGE_RX] !== 1'b1 && n < 40);
	endtask : poll_page

	task automatic settle;
		repeat (3) @(posedge clock);
	endtask : settle

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		{rst_n, avs_read, avs_write, link_up, send_next} = 5'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		{pma_signal_detect, gpio_signal_detect} = 2'h3;
		tx_code_in = 10'h2A5;
		gap = 4'h2;
		base_word = 16'h8421;
		np_word = 16'h1234;
		err_total = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk("cfg_reset", OFS_CFG, ALL, 32'h00000000);
		rd_chk("sd_reset", OFS_SD_CFG, ALL, 32'h00000002);
		bus(1'b1, 8'h3C, ALL);
		rd_chk("unmapped", 8'h3C, ALL, 32'h00000000);
		rd_chk("cnt_reset", OFS_LOSS_CNT, ALL, 32'h00000000);
		// Mode, one-way transmit and loopback
		bus(1'b1, OFS_CFG, 32'h00000003);
		settle();
		check("mode_sel", phy_side_serial_mode_select, 1);
		check("tx_no_link", tx_enable, 0);
		bus(1'b1, OFS_CFG, 32'h00000007);
		settle();
		check("tx_one_way", tx_enable, 1);
		bus(1'b1, OFS_CFG, 32'h0000000B);
		settle();
		check("loop_on", rx_code_out, 10'h2A5);
		bus(1'b1, OFS_CFG, 32'h00000003);
		settle();
		check("loop_off", rx_code_out, 10'h17C);
		// Signal detect reaction, polarity and source
		bus(1'b1, OFS_SD_CFG, 32'h00000003);
		pma_signal_detect <= 1'b0;
		settle();
		check("loss_restart", rx_restart, 1);
		check("loss_frames", rx_frame_enable, 0);
		pma_signal_detect <= 1'b1;
		settle();
		check("signal_ok", rx_restart, 0);
		bus(1'b1, OFS_SD_CFG, 32'h00000001);
		settle();
		check("pol_low", rx_restart, 1);
		rd_chk("raw_pma", OFS_LINK_STAT, 32'h4, 32'h4);
		gpio_signal_detect <= 1'b0;
		bus(1'b1, OFS_SD_CFG, 32'h00000005);
		settle();
		check("src_gpio", rx_restart, 0);
		rd_chk("raw_gpio", OFS_LINK_STAT, 32'h4, 32'h0);
		bus(1'b1, OFS_SD_CFG, 32'h00000000);
		settle();
		check("react_off", rx_restart, 0);
		check("react_off_rx", rx_frame_enable, 1);
		gpio_signal_detect <= 1'b1;
		bus(1'b1, OFS_SD_CFG, 32'h00000002);
		// Base page, one next page, idle detect, link good
		// Negotiation goes on before lock so no off-good state arms the loss timer
		bus(1'b1, OFS_ANEG_CFG, 32'hC1A00001);
		link_up <= 1'b1;
		settle();
		check("page_on", tx_page_active, 1);
		check("base_tx", tx_page_word, 16'hC1A0);
		rd_chk("sync_bit", OFS_LINK_STAT, 32'h2, 32'h2);
		poll_page();
		rd_chk("base_rx", OFS_ANEG_STAT, 32'hFFFF0007, 32'h84210001);
		rd_chk("sgmii_link", OFS_LINK_STAT, 32'h1, 32'h1);
		gap <= 4'hC;
		send_next <= 1'b1;
		bus(1'b1, OFS_ANEG_STAT, 32'h00000001);
		rd_chk("page_clr", OFS_ANEG_STAT, 32'h1, 32'h0);
		bus(1'b1, OFS_NP_CFG, 32'h0B550001);
		settle();
		check("np_tx", tx_page_word, 16'h0B55);
		poll_page();
		rd_chk("np_rx", OFS_NP_STAT, 32'hFFFF, 32'h1234);
		rd_chk("pr_set", OFS_ANEG_STAT, 32'h7, 32'h3);
		repeat (SG_CYC + 5) @(posedge clock);
		rd_chk("done", OFS_ANEG_STAT, 32'h6, 32'h6);
		check("tx_good", tx_enable, 1);
		rd_chk("no_loss", OFS_LOSS_CNT, 32'hFF, 32'h0);
		// Renegotiate with a partner whose PHY reports link down
		base_word <= 16'h0421;
		send_next <= 1'b0;
		gap <= 4'h9;
		bus(1'b1, OFS_ANEG_CFG, 32'h41A00003);
		rd_chk("restarted", OFS_ANEG_STAT, 32'h6, 32'h0);
		rd_chk("restart_rb", OFS_ANEG_CFG, ALL, 32'h41A00001);
		repeat (2 * SG_CYC) @(posedge clock);
		rd_chk("done_again", OFS_ANEG_STAT, 32'h6, 32'h6);
		rd_chk("phy_link", OFS_LINK_STAT, 32'h1, 32'h0);
		rd_chk("cnt_reneg", OFS_LOSS_CNT, 32'hFF, 32'h1);
		rd_chk("stk_reneg", OFS_STICKY, 32'h1, 32'h1);
		bus(1'b1, OFS_STICKY, 32'h00000001);
		rd_chk("stk_clr", OFS_STICKY, 32'h1, 32'h0);
		// Loss of sync in SGMII mode
		link_up <= 1'b0;
		settle(); // Lock loss reaches the status bit two cycles later
		rd_chk("sync_lost", OFS_LINK_STAT, 32'h2, 32'h0);
		rd_chk("sg_early", OFS_STICKY, 32'h1, 32'h0);
		repeat (SG_CYC + 10) @(posedge clock);
		rd_chk("sg_loss", OFS_STICKY, 32'h1, 32'h1);
		rd_chk("cnt_sg", OFS_LOSS_CNT, 32'hFF, 32'h2);
		// 1000BASE-X with negotiation off
		bus(1'b1, OFS_STICKY, 32'h00000001);
		bus(1'b1, OFS_CFG, 32'h00000001);
		bus(1'b1, OFS_ANEG_CFG, 32'h00000000);
		link_up <= 1'b1;
		repeat (5) @(posedge clock);
		rd_chk("x_link", OFS_LINK_STAT, 32'h1, 32'h1);
		check("off_good", tx_enable, 1);
		link_up <= 1'b0;
		repeat (24) @(posedge clock);
		rd_chk("sx_early", OFS_STICKY, 32'h1, 32'h0);
		repeat (30) @(posedge clock);
		rd_chk("sx_loss", OFS_STICKY, 32'h1, 32'h1);
		rd_chk("cnt_sx", OFS_LOSS_CNT, 32'hFF, 32'h3);
		// Sublayer off stops transmit and receive framing
		bus(1'b1, OFS_CFG, 32'h00000004);
		settle();
		check("off_tx", tx_enable, 0);
		check("off_rx", rx_frame_enable, 0);
		tally_and_finish();
	end
endmodule : gpa_pcs_link_ctrl_test
